//--- src/acp_pkg.sv
// Purpose: Shared constants for the audio DAC serial control port.
// Assumes: Field positions count from bit 0 of the 16-bit serial word.
// Notes: Bits 1:0 of every word carry the register select code.

package acp_pkg;

  // ---------------------------------------------------------------
  // Serial word layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int VAL_BITS = 14;
  localparam int SEL_LSB = 0;
  localparam int VAL_LSB = 2;

  localparam logic [1:0] SEL_VOL_LEFT = 2'h0;
  localparam logic [1:0] SEL_CTL = 2'h1;
  localparam logic [1:0] SEL_VOL_RIGHT = 2'h2;

  // ---------------------------------------------------------------
  // Control word field positions (in the 16-bit word)
  // ---------------------------------------------------------------
  localparam int POS_INTERP_DOUBLE_RATE = 11;
  localparam int POS_INTERP_QUAD_RATE = 10;
  localparam int POS_WLEN = 8;
  localparam int POS_SOFT_RST = 7;
  localparam int POS_SOFT_MUTE = 6;
  localparam int POS_FMT = 4;
  localparam int POS_DEEMPH = 2;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] WLEN_24 = 2'h0;
  localparam logic [1:0] WLEN_20 = 2'h1;
  localparam logic [1:0] WLEN_16 = 2'h2;
  localparam logic [4:0] BITS_24 = 5'h18;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [1:0] FMT_RIGHT_JUST = 2'h0;
  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_44K1 = 2'h1;
  localparam logic [1:0] INTERP_8X = 2'h0;
  localparam logic [1:0] INTERP_4X = 2'h1;
  localparam logic [1:0] INTERP_2X = 2'h2;
  localparam logic [13:0] VOL_RST = 14'h3fff;
  localparam logic [13:0] RAMP_STEP_DEF = 14'h0040;
  localparam int GROUP_DELAY_DEF = 32;
  localparam int RESUME_EXTRA_CYC = 3;

endpackage : acp_pkg

//--- src/acp_pin_sync.sv
// Purpose: Two-flop synchroniser with edge detect for a group of pins.
// Assumes: Pins are asynchronous to CLK.
// Notes: Edges come from stages two and three, never from stage one.

`timescale 1ns/1ps

module acp_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out = sync_ff & ~prev_ff;
  assign fall_out = ~sync_ff & prev_ff;

endmodule : acp_pin_sync

//--- src/acp_gain_ramp.sv
// Purpose: Per-channel gain that follows the volume on frame edges, ramping on mute.
// Assumes: en is a one-cycle pulse on each frame clock edge.
// Notes: Ramps around mute and after reset; plain volume changes step at the frame edge.

`timescale 1ns/1ps

module acp_gain_ramp #(
  parameter int W = 14,
  parameter logic [W-1:0] STEP = 14'h0040
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic mute,
  input wire logic [W-1:0] target,
  output logic [W-1:0] gain
);

  logic [W-1:0] gain_ff;
  logic rising_ff;
  logic [W:0] up_sum;

  assign up_sum = {1'b0, gain_ff} + {1'b0, STEP};

  always_ff @(posedge clk) begin
    if (rst) begin
      gain_ff <= '0;
      rising_ff <= 1'b1;
    end else if (en) begin
      if (mute) begin  // [RQ7] [RQ9]
        gain_ff <= (gain_ff > STEP) ? gain_ff - STEP : '0;
        rising_ff <= 1'b1;
      end else if (rising_ff) begin  // [RQ9]
        if (up_sum >= {1'b0, target}) begin
          gain_ff <= target;
          rising_ff <= 1'b0;
        end else begin
          gain_ff <= up_sum[W-1:0];
        end
      end else begin
        gain_ff <= target;  // [RQ6]
      end
    end
  end

  assign gain = gain_ff;

  chk_ramp_down: assert property (@(posedge clk) disable iff (rst)
    en && mute && gain_ff != '0 |=> gain_ff < $past(gain_ff))  // [RQ9]
    else $error("gain did not ramp down while muted");
  chk_frame_apply: assert property (@(posedge clk) disable iff (rst)
    en && !mute && !rising_ff |=> gain_ff == $past(target))  // [RQ6]
    else $error("volume not applied at frame edge");
  chk_gain_hold: assert property (@(posedge clk) disable iff (rst)
    !en |=> $stable(gain_ff))  // [RQ6]
    else $error("gain changed between frame edges");

endmodule : acp_gain_ramp

//--- src/acp_top.sv
// Purpose: Three-wire serial control port and control logic of a stereo audio DAC.
// Assumes: CLK is the master clock; all link and mode pins are asynchronous to it.
// Notes: Serial clock is oversampled, so it must stay well below CLK/4.
//
// Contract
// (RQ1) Shift one data bit into the shift register on each rising control clock.
// (RQ2) Controller changes data on falling control clock, stable at rising edge.
// (RQ3) Rising commit strobe copies the shift register into the addressed register.
// (RQ4) Controller raises commit strobe at the last falling clock of a frame.
// (RQ5) Free-running control clock never alters registers; only the strobe commits.
// (RQ6) New volume takes effect at the next frame clock edge after commit.
// (RQ7) Hardware mute input high mutes both channels.
// (RQ8) Soft mute bit ORs with hardware mute; resets to zero.
// (RQ9) Mute and unmute ramp the gain; unmute returns to the volume register.
// (RQ10) Select code 01 writes the upper 14 bits into the control register.
// (RQ11) Bits 11 and 10 pick 2x and 4x, ORed with pins; default 8x.
// (RQ12) Wordlength code 00 is 24, 01 is 20, 10 is 16; default 00.
// (RQ13) Format field ORed with format pins: RJ, I2S, LJ, DSP; default 00.
// (RQ14) De-emphasis field: none, 44.1, 32, 48 kHz; default none.
// (RQ15) External emphasis input enables the 44.1 kHz curve on its own.
// (RQ16) Controller should hold emphasis input low when using the field.
// (RQ17) During hardware or software reset, suspend operation, outputs midscale.
// (RQ18) Controller resets at power-up for at least 64 master clocks.
// (RQ19) Output resumes group delay plus three master clocks after reset release.
// (RQ20) Hardware reset low loads defaults into all registers.
// (RQ21) Software reset bit resets internal state but keeps register values.
// (RQ22) Format pins may change at any time; controller should mute first.
// (RQ23) Each write is 16 bits MSB first: two select bits, fourteen value bits.
// (RQ24) Select 00 left volume, 10 right volume, 01 control register.
// (RQ25) Select 11 and unused high control bits are ignored.

`timescale 1ns/1ps

module acp_top
  import acp_pkg::*;
#(
  parameter int GROUP_DELAY_CYC = GROUP_DELAY_DEF,
  parameter logic [13:0] RAMP_STEP = RAMP_STEP_DEF
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic RESET_N,
  input wire logic CTL_SHIFT_CLOCK,
  input wire logic CTL_SERIAL_IN,
  input wire logic CTL_COMMIT_STROBE,
  input wire logic LR_FRAME_CLOCK,
  input wire logic MUTE_IN,
  input wire logic EMPHASIS_44K_IN,
  input wire logic FORMAT_SEL_LO,
  input wire logic FORMAT_SEL_HI,
  input wire logic INTERP_DOUBLE_RATE,
  input wire logic INTERP_QUAD_RATE,
  output logic [13:0] LEFT_GAIN,
  output logic [13:0] RIGHT_GAIN,
  output logic MUTE_ACTIVE,
  output logic [1:0] INTERP_MODE,
  output logic [4:0] WORD_LENGTH,
  output logic [1:0] SERIAL_FORMAT,
  output logic [1:0] DEEMPH_SELECT,
  output logic OUTPUT_MIDSCALE
);

  localparam int RESUME_CYC = GROUP_DELAY_CYC + RESUME_EXTRA_CYC;
  localparam int CNT_W = $clog2(RESUME_CYC + 1);
  localparam logic [CNT_W-1:0] RESUME_LAST = CNT_W'(RESUME_CYC - 1);
  localparam int RESUME_I = RESUME_CYC;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [4:0] wlen_bits(input logic [1:0] code);
    case (code)
      WLEN_20: wlen_bits = BITS_20;
      WLEN_16: wlen_bits = BITS_16;
      default: wlen_bits = BITS_24;
    endcase
  endfunction : wlen_bits

  function automatic logic [1:0] interp_pick(input logic dbl, input logic quad);
    if (dbl) begin
      interp_pick = INTERP_2X;
    end else if (quad) begin
      interp_pick = INTERP_4X;
    end else begin
      interp_pick = INTERP_8X;
    end
  endfunction : interp_pick

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] link_lvl;
  logic [3:0] link_rise;
  logic [3:0] link_fall;
  logic [7:0] mode_lvl;

  acp_pin_sync #(.W(4)) u_link_sync (
    .clk(CLK),
    .srst(SRST),
    .pin_in({LR_FRAME_CLOCK, CTL_COMMIT_STROBE, CTL_SERIAL_IN, CTL_SHIFT_CLOCK}),
    .level_out(link_lvl),
    .rise_out(link_rise),
    .fall_out(link_fall)
  );

  // Static pins; changes are legal at any time, so only levels are needed
  acp_pin_sync #(.W(8)) u_mode_sync (
    .clk(CLK),
    .srst(SRST),
    .pin_in({RESET_N, MUTE_IN, EMPHASIS_44K_IN, FORMAT_SEL_HI, FORMAT_SEL_LO,
             INTERP_DOUBLE_RATE, INTERP_QUAD_RATE, 1'b0}),
    .level_out(mode_lvl),
    .rise_out(),
    .fall_out()
  );

  logic shift_rise;
  logic data_s;
  logic commit;
  logic frame_edge;
  logic hw_rst;
  logic mute_pin_s;
  logic emph_pin_s;
  logic [1:0] fmt_pin_s;
  logic dbl_pin_s;
  logic quad_pin_s;

  assign shift_rise = link_rise[0];
  assign data_s = link_lvl[1];
  assign commit = link_rise[2];
  assign frame_edge = link_rise[3] | link_fall[3];
  assign hw_rst = ~mode_lvl[7];
  assign mute_pin_s = mode_lvl[6];
  assign emph_pin_s = mode_lvl[5];
  assign fmt_pin_s = mode_lvl[4:3];
  assign dbl_pin_s = mode_lvl[2];
  assign quad_pin_s = mode_lvl[1];

  // ---------------------------------------------------------------
  // Serial shift register
  // ---------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_ff;
  logic [1:0] sel;
  logic [VAL_BITS-1:0] value;

  // Data and clock share the same sync latency, so data is still stable here
  always_ff @(posedge CLK) begin
    if (SRST || hw_rst) begin
      shift_ff <= '0;
    end else if (shift_rise) begin
      shift_ff <= {shift_ff[FRAME_BITS-2:0], data_s};  // [RQ1] [RQ2] [RQ23]
    end
  end

  assign sel = shift_ff[SEL_LSB +: 2];
  assign value = shift_ff[VAL_LSB +: VAL_BITS];

  // ---------------------------------------------------------------
  // Volume registers
  // ---------------------------------------------------------------
  logic [VAL_BITS-1:0] vol_left_ff;
  logic [VAL_BITS-1:0] vol_right_ff;

  always_ff @(posedge CLK) begin
    if (SRST || hw_rst) begin  // [RQ20]
      vol_left_ff <= VOL_RST;
      vol_right_ff <= VOL_RST;
    end else if (commit) begin  // [RQ3] [RQ5]
      if (sel == SEL_VOL_LEFT) begin  // [RQ24]
        vol_left_ff <= value;
      end
      if (sel == SEL_VOL_RIGHT) begin  // [RQ24]
        vol_right_ff <= value;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic interp_double_rate_ff;
  logic interp_quad_rate_ff;
  logic [1:0] wlen_ff;
  logic soft_rst_ff;
  logic soft_mute_ff;
  logic [1:0] fmt_ff;
  logic [1:0] deemph_ff;

  // Bits above the interpolation flags are dropped, never stored
  always_ff @(posedge CLK) begin
    if (SRST || hw_rst) begin  // [RQ20]
      interp_double_rate_ff <= 1'b0;
      interp_quad_rate_ff <= 1'b0;
      wlen_ff <= WLEN_24;
      soft_rst_ff <= 1'b0;
      soft_mute_ff <= 1'b0;
      fmt_ff <= FMT_RIGHT_JUST;
      deemph_ff <= DEEMPH_NONE;
    end else if (commit && sel == SEL_CTL) begin  // [RQ10] [RQ25]
      interp_double_rate_ff <= shift_ff[POS_INTERP_DOUBLE_RATE];  // [RQ11]
      interp_quad_rate_ff <= shift_ff[POS_INTERP_QUAD_RATE];
      wlen_ff <= shift_ff[POS_WLEN +: 2];  // [RQ12]
      soft_rst_ff <= shift_ff[POS_SOFT_RST];  // [RQ21]
      soft_mute_ff <= shift_ff[POS_SOFT_MUTE];  // [RQ8]
      fmt_ff <= shift_ff[POS_FMT +: 2];  // [RQ13]
      deemph_ff <= shift_ff[POS_DEEMPH +: 2];  // [RQ14]
    end
  end

  // ---------------------------------------------------------------
  // Reset sequencing and resume delay
  // ---------------------------------------------------------------
  logic core_rst;
  logic mid_ff;
  logic [CNT_W-1:0] resume_cnt_ff;

  // Soft reset stops the core but leaves the register file alone
  assign core_rst = hw_rst | soft_rst_ff;  // [RQ17] [RQ21]

  always_ff @(posedge CLK) begin
    if (SRST || core_rst) begin
      mid_ff <= 1'b1;  // [RQ17]
      resume_cnt_ff <= '0;
    end else if (mid_ff) begin
      if (resume_cnt_ff == RESUME_LAST) begin  // [RQ19]
        mid_ff <= 1'b0;
      end else begin
        resume_cnt_ff <= resume_cnt_ff + 1'b1;
      end
    end
  end

  assign OUTPUT_MIDSCALE = mid_ff;

  // ---------------------------------------------------------------
  // Channel gains
  // ---------------------------------------------------------------
  logic ramp_rst;

  assign ramp_rst = SRST | core_rst | mid_ff;

  acp_gain_ramp #(.W(VAL_BITS), .STEP(RAMP_STEP)) u_left_ramp (
    .clk(CLK),
    .rst(ramp_rst),
    .en(frame_edge),
    .mute(MUTE_ACTIVE),
    .target(vol_left_ff),
    .gain(LEFT_GAIN)
  );

  acp_gain_ramp #(.W(VAL_BITS), .STEP(RAMP_STEP)) u_right_ramp (
    .clk(CLK),
    .rst(ramp_rst),
    .en(frame_edge),
    .mute(MUTE_ACTIVE),
    .target(vol_right_ff),
    .gain(RIGHT_GAIN)
  );

  // ---------------------------------------------------------------
  // Effective modes; all register fields but word length ORed with pins
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      MUTE_ACTIVE <= 1'b0;
    end else begin
      MUTE_ACTIVE <= mute_pin_s | soft_mute_ff;  // [RQ7] [RQ8]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      INTERP_MODE <= INTERP_8X;
      WORD_LENGTH <= BITS_24;
    end else begin
      INTERP_MODE <= interp_pick(interp_double_rate_ff | dbl_pin_s, interp_quad_rate_ff | quad_pin_s);  // [RQ11]
      WORD_LENGTH <= wlen_bits(wlen_ff);  // [RQ12]
    end
  end

  // Pins are resynchronised every cycle, so a live change just follows through
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SERIAL_FORMAT <= FMT_RIGHT_JUST;
      DEEMPH_SELECT <= DEEMPH_NONE;
    end else begin
      SERIAL_FORMAT <= fmt_ff | fmt_pin_s;  // [RQ13] [RQ22]
      DEEMPH_SELECT <= deemph_ff | (emph_pin_s ? DEEMPH_44K1 : DEEMPH_NONE);  // [RQ15]
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence s_ctl_commit;
    !hw_rst && commit && sel == SEL_CTL;
  endsequence

  sequence s_reset_release;
    $fell(core_rst);
  endsequence

  chk_shift_in_bit: assert property (  // [RQ1]
    !hw_rst && shift_rise |=> shift_ff == {$past(shift_ff[14:0]), $past(data_s)})
    else $error("shift register did not take the serial bit");

  chk_commit_left: assert property (  // [RQ3]
    !hw_rst && commit && sel == SEL_VOL_LEFT |=> vol_left_ff == $past(value))
    else $error("left volume not committed");

  chk_commit_right: assert property (  // [RQ24]
    !hw_rst && commit && sel == SEL_VOL_RIGHT |=> vol_right_ff == $past(value)
      && $stable(vol_left_ff))
    else $error("right volume decode wrong");

  chk_ctl_fields: assert property (  // [RQ10]
    s_ctl_commit |=> soft_mute_ff == $past(shift_ff[POS_SOFT_MUTE])
      && wlen_ff == $past(shift_ff[9:8]) && $stable(vol_left_ff))
    else $error("control word fields not stored");

  chk_no_commit_hold: assert property (  // [RQ5]
    !hw_rst && !commit |=> $stable(vol_left_ff) && $stable(vol_right_ff)
      && $stable(fmt_ff) && $stable(interp_double_rate_ff))
    else $error("register changed without a commit");

  chk_sel11_ignored: assert property (  // [RQ25]
    !hw_rst && commit && sel == 2'h3 |=> $stable(vol_left_ff) && $stable(vol_right_ff)
      && $stable(deemph_ff) && $stable(soft_rst_ff))
    else $error("select code 11 altered state");

  chk_mute_or: assert property (  // [RQ7]
    mute_pin_s || soft_mute_ff |=> MUTE_ACTIVE)
    else $error("mute not asserted");

  chk_interp_mode: assert property (  // [RQ11]
    (interp_double_rate_ff || dbl_pin_s) |=> INTERP_MODE == INTERP_2X)
    else $error("2x mode not selected");

  chk_emph_pin: assert property (  // [RQ15]
    emph_pin_s |=> DEEMPH_SELECT[0])
    else $error("emphasis pin did not select 44.1 kHz");

  chk_hw_defaults: assert property (  // [RQ20]
    hw_rst |=> vol_left_ff == VOL_RST && fmt_ff == FMT_RIGHT_JUST && !soft_mute_ff
      && OUTPUT_MIDSCALE)
    else $error("hardware reset did not load defaults");

  chk_soft_keeps: assert property (  // [RQ21]
    soft_rst_ff && !hw_rst && !commit |=> $stable(vol_left_ff) && $stable(fmt_ff)
      && OUTPUT_MIDSCALE && LEFT_GAIN == '0)
    else $error("soft reset disturbed registers");

  chk_resume_delay: assert property (disable iff (SRST || core_rst)  // [RQ19]
    s_reset_release |-> OUTPUT_MIDSCALE ##RESUME_I !OUTPUT_MIDSCALE)
    else $error("resume delay wrong");

endmodule : acp_top

//--- test/acp_host_model.sv
// Purpose: Behavioural controller that drives the three-wire control port.
// Assumes: Called from the bench right after a rising CLK edge.
// Notes: half_cyc sets the link speed; 16 gives a 160 ns shift clock.

`timescale 1ns/1ps

module acp_host_model #(
  parameter int HALF_CYC = 16
) (
  input wire logic clk,
  output logic shift_clk,
  output logic serial_in,
  output logic commit_strobe
);
  int half_cyc = HALF_CYC;

  initial begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    commit_strobe = 1'b0;
  end

  // ---------------------------------------------------------------
  // Link tasks
  // ---------------------------------------------------------------
  task automatic half_wait();
    repeat (half_cyc) @(posedge clk);
  endtask : half_wait

  // Data only moves while the shift clock is low
  task automatic shift_bits(input logic [15:0] word);
    for (int i = 15; i >= 0; i--) begin
      shift_clk <= 1'b0;
      serial_in <= word[i];
      half_wait();
      shift_clk <= 1'b1;
      half_wait();
    end
  endtask : shift_bits

  task automatic send_word(input logic [15:0] word);
    shift_bits(word);
    shift_clk <= 1'b0;
    commit_strobe <= 1'b1;
    // Hold time over, so the line no longer shows the last bit
    serial_in <= ~word[0];
    half_wait();
    commit_strobe <= 1'b0;
    half_wait();
  endtask : send_word

  // Clock keeps running between words with no strobe
  task automatic idle_clocks(input logic [15:0] noise);
    shift_bits(noise);
    shift_clk <= 1'b0;
    serial_in <= ~noise[0];
    half_wait();
  endtask : idle_clocks

endmodule : acp_host_model

//--- test/audio_dac_serial_control_port_bench.sv
// Purpose: Self-checking bench for the control port and control logic.
// Assumes: Short group delay and a large ramp step keep the run short.
// Notes: Checks sample at the rising edge, before that edge's updates land.

`timescale 1ns/1ps

module audio_dac_serial_control_port_bench;
  import acp_pkg::*;

  localparam int GD = 4;
  localparam logic [13:0] STEP = 14'h1000;
  localparam int TIMEOUT_CYC = 60000;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reset_n = 1'b1;
  logic lrck = 1'b0;
  logic mute_in = 1'b0;
  logic emph_in = 1'b0;
  logic fmt_lo = 1'b0;
  logic fmt_hi = 1'b0;
  logic interp_double_rate_in = 1'b0;
  logic interp_quad_rate_in = 1'b0;
  logic shift_clk, serial_in, commit;
  logic [13:0] left_gain, right_gain;
  logic mute_active, midscale;
  logic [1:0] interp_mode, serial_format, deemph_select;
  logic [4:0] word_length;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  acp_top #(.GROUP_DELAY_CYC(GD), .RAMP_STEP(STEP)) u_dut (
    .CLK(clk), .SRST(srst), .RESET_N(reset_n), .CTL_SHIFT_CLOCK(shift_clk),
    .CTL_SERIAL_IN(serial_in), .CTL_COMMIT_STROBE(commit), .LR_FRAME_CLOCK(lrck),
    .MUTE_IN(mute_in), .EMPHASIS_44K_IN(emph_in), .FORMAT_SEL_LO(fmt_lo),
    .FORMAT_SEL_HI(fmt_hi), .INTERP_DOUBLE_RATE(interp_double_rate_in), .INTERP_QUAD_RATE(interp_quad_rate_in),
    .LEFT_GAIN(left_gain), .RIGHT_GAIN(right_gain), .MUTE_ACTIVE(mute_active),
    .INTERP_MODE(interp_mode), .WORD_LENGTH(word_length), .SERIAL_FORMAT(serial_format),
    .DEEMPH_SELECT(deemph_select), .OUTPUT_MIDSCALE(midscale)
  );

  acp_host_model u_host (
    .clk(clk), .shift_clk(shift_clk), .serial_in(serial_in), .commit_strobe(commit)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [13:0] got, input logic [13:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_modes(input logic [1:0] im, input logic [4:0] wl,
                             input logic [1:0] fm, input logic [1:0] dm);
    check_val(14'(interp_mode), 14'(im), "interp");
    check_val(14'(word_length), 14'(wl), "wordlength");
    check_val(14'(serial_format), 14'(fm), "format");
    check_val(14'(deemph_select), 14'(dm), "deemph");
  endtask : check_modes

  task automatic check_gains(input logic [13:0] l, input logic [13:0] r);
    check_val(left_gain, l, "left gain");
    check_val(right_gain, r, "right gain");
  endtask : check_gains

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task automatic frame_edges(input int n);
    repeat (n) begin
      lrck <= ~lrck;
      wait_cyc(8);
    end
  endtask : frame_edges

  task automatic write_reg(input logic [1:0] sel, input logic [13:0] val);
    u_host.send_word({val, sel});
    wait_cyc(8);
  endtask : write_reg

  task automatic write_ctl(input logic [1:0] wl, input logic [1:0] fm, input logic [1:0] dm,
                           input logic mute, input logic rst, input logic i2, input logic i4);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_INTERP_DOUBLE_RATE] = i2;
    w[POS_INTERP_QUAD_RATE] = i4;
    w[POS_WLEN +: 2] = wl;
    w[POS_SOFT_RST] = rst;
    w[POS_SOFT_MUTE] = mute;
    w[POS_FMT +: 2] = fm;
    w[POS_DEEMPH +: 2] = dm;
    w[1:0] = SEL_CTL;
    write_reg(w[1:0], w[15:2]);
  endtask : write_ctl

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_fields();
    logic [4:0] lens [3] = '{BITS_24, BITS_20, BITS_16};
    check_modes(INTERP_8X, BITS_24, FMT_RIGHT_JUST, DEEMPH_NONE);
    check_val(14'(mute_active), 14'h0000, "mute");
    // Fast link on one word: shortest legal levels
    u_host.half_cyc = 8;
    for (int i = 0; i < 4; i++) begin
      write_ctl(2'(i % 3), 2'(i), 2'(i), 0, 0, 0, 0);
      check_modes(INTERP_8X, lens[i % 3], 2'(i), 2'(i));
      u_host.half_cyc = 16;
    end
    write_ctl(0, 0, 0, 0, 0, 0, 1);
    check_modes(INTERP_4X, BITS_24, 0, 0);
    write_ctl(0, 0, 0, 0, 0, 1, 1);
    check_modes(INTERP_2X, BITS_24, 0, 0);
    write_ctl(0, 0, 2, 0, 0, 0, 0);
    emph_in <= 1'b1;
    wait_cyc(6);
    check_modes(INTERP_8X, BITS_24, 0, 3);
    write_ctl(0, 0, 0, 0, 0, 0, 0);
    check_modes(INTERP_8X, BITS_24, 0, DEEMPH_44K1);
    emph_in <= 1'b0;
    mute_in <= 1'b1;
    interp_quad_rate_in <= 1'b1;
    fmt_lo <= 1'b1;
    wait_cyc(6);
    check_modes(INTERP_4X, BITS_24, 1, 0);
    interp_double_rate_in <= 1'b1;
    fmt_hi <= 1'b1;
    wait_cyc(6);
    check_modes(INTERP_2X, BITS_24, 3, 0);
    {interp_double_rate_in, interp_quad_rate_in, fmt_lo, fmt_hi, mute_in} <= 5'h00;
    wait_cyc(6);
  endtask : t_fields

  task automatic t_ignored();
    u_host.send_word(16'h0125);
    wait_cyc(8);
    check_modes(INTERP_8X, BITS_20, 2, 1);
    // Non-default value, so a stray volume write would show later
    write_reg(2'h3, 14'h0abc);
    u_host.send_word(16'hf125);
    wait_cyc(8);
    check_modes(INTERP_8X, BITS_20, 2, 1);
    u_host.idle_clocks(16'hfffd);
    wait_cyc(8);
    check_modes(INTERP_8X, BITS_20, 2, 1);
    check_val(14'(mute_active), 14'h0000, "mute");
  endtask : t_ignored

  task automatic t_volume();
    frame_edges(5);
    check_gains(VOL_RST, VOL_RST);
    write_reg(SEL_VOL_LEFT, 14'h2000);
    check_gains(VOL_RST, VOL_RST);
    frame_edges(1);
    check_gains(14'h2000, VOL_RST);
    write_reg(SEL_VOL_RIGHT, 14'h1234);
    frame_edges(1);
    check_gains(14'h2000, 14'h1234);
  endtask : t_volume

  task automatic t_mute();
    mute_in <= 1'b1;
    wait_cyc(6);
    check_val(14'(mute_active), 14'h0001, "mute");
    frame_edges(1);
    check_gains(14'h2000 - STEP, 14'h1234 - STEP);
    frame_edges(1);
    check_gains(14'h0000, 14'h0000);
    mute_in <= 1'b0;
    // Mute path is one register longer than the frame edge path
    wait_cyc(6);
    check_val(14'(mute_active), 14'h0000, "unmute");
    frame_edges(1);
    check_gains(STEP, STEP);
    frame_edges(1);
    check_gains(14'h2000, 14'h1234);
    write_ctl(0, 0, 0, 1, 0, 0, 0);
    check_val(14'(mute_active), 14'h0001, "soft mute");
    frame_edges(2);
    check_gains(14'h0000, 14'h0000);
    write_ctl(0, 0, 0, 0, 0, 0, 0);
    frame_edges(3);
    check_gains(14'h2000, 14'h1234);
  endtask : t_mute

  task automatic t_resets();
    int n;
    write_ctl(0, 0, 0, 0, 1, 0, 0);
    check_val(14'(midscale), 14'h0001, "midscale");
    check_gains(14'h0000, 14'h0000);
    write_ctl(0, 0, 0, 0, 0, 0, 0);
    frame_edges(3);
    check_gains(14'h2000, 14'h1234);
    write_ctl(2, 3, 3, 0, 0, 0, 0);
    check_modes(INTERP_8X, BITS_16, 3, 3);
    reset_n <= 1'b0;
    wait_cyc(64);
    check_val(14'(midscale), 14'h0001, "midscale");
    check_gains(14'h0000, 14'h0000);
    check_modes(INTERP_8X, BITS_24, 0, 0);
    reset_n <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (midscale === 1'b0) break;
    end
    check_val(14'(n >= GD + 3 && n <= GD + 9), 14'h0001, "resume delay");
    frame_edges(5);
    check_gains(VOL_RST, VOL_RST);
  endtask : t_resets

  // ---------------------------------------------------------------
  // Sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles >= TIMEOUT_CYC) begin
      fails++;
      $display("ERROR t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  initial begin
    wait_cyc(6);
    srst <= 1'b0;
    wait_cyc(GD + 20);
    t_fields();
    t_ignored();
    t_volume();
    t_mute();
    t_resets();
    print_verdict();
  end

endmodule : audio_dac_serial_control_port_bench
